//--- hdl/clamp_fmt_regs.sv
// Clamp window and output format registers of the video decoder
// Summary of operation
// RL1: Clamp pulse ends at programmed time after horizontal sync detection.
// RL2: End time counts whole clocks after a fixed one-clock sync delay.
// RL3: Ten-bit end time; low byte at 0x14, top two bits 0x15.
// RL4: End time resets to 0x52 low, 00 high; other upper bits unused.
// RL5: Clamp pulse drives the converter clamp gate input.
// RL6: Format bit 7 selects square pixel when 1, BT601 when 0.
// RL7: Bits 6 to 4 choose which fields reach the data port.
// RL8: Format bit 3 selects 8-bit burst when 1, 16-bit when 0.
// RL9: Format bit 2 enables video output pins; 0 floats them.
// RL10: Format bit 1 zero gives half-line chroma offset; one aligns.
// RL11: Siting bit clears on reset.
// RL12: Format bit 0 ignores writes and reads zero.
// RL13: Clamp start is a ten-bit delay at 0x12 and 0x13.
// RL14: Pulse high while line counter lies between start and end.
`default_nettype none
module clamp_fmt_regs
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Video timing
  input wire logic hsync_detect,
  input wire logic field_odd,
  input wire logic field_start,
  input wire logic data_valid_in,
  // Converter clamp
  output logic clamp_gate_input,
  // Format controls
  output logic square_pixel,
  output logic burst_8bit,
  output logic line_aligned_chroma,
  output logic field_capture,
  // Pin drive
  output logic output_drive_enable,
  output logic data_valid_out
);
  // ==========================================================
  // Registers
  logic [7:0] start_low_reg;
  logic [1:0] start_high_reg;
  logic [7:0] end_low_reg;
  logic [1:0] end_high_reg;
  clamp_fmt_pkg::output_format_s fmt_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [1:0] field_cnt_reg;
  logic capture_reg;
  logic capture_next;

  clamp_fmt_pkg::reg_req_s req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire wr_start_low = req.wr && hit(req.addr,
    clamp_fmt_pkg::clamp_start_low_off);
  wire wr_start_high = req.wr && hit(req.addr,
    clamp_fmt_pkg::clamp_start_high_off);
  wire wr_end_low = req.wr && hit(req.addr,
    clamp_fmt_pkg::clamp_end_low_off);
  wire wr_end_high = req.wr && hit(req.addr,
    clamp_fmt_pkg::clamp_end_high_off);
  wire wr_fmt = req.wr && hit(req.addr, clamp_fmt_pkg::output_format_off);

  wire [7:0] fmt_read = {fmt_reg, 1'b0};

  // ==========================================================
  // Read decode
  // RL12: bit 0 reads zero; unmapped addresses read zero
  always_comb
  begin
    if (hit(req.addr, clamp_fmt_pkg::clamp_start_low_off))
      rdata_next = start_low_reg;
    else if (hit(req.addr, clamp_fmt_pkg::clamp_start_high_off))
      rdata_next = {6'h00, start_high_reg};
    else if (hit(req.addr, clamp_fmt_pkg::clamp_end_low_off))
      rdata_next = end_low_reg;
    else if (hit(req.addr, clamp_fmt_pkg::clamp_end_high_off))
      rdata_next = {6'h00, end_high_reg};
    else if (hit(req.addr, clamp_fmt_pkg::output_format_off))
      rdata_next = fmt_read;
    else
      rdata_next = 8'h00;
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      // RL4: end time reset values
      start_low_reg <= clamp_fmt_pkg::clamp_start_low_rst;
      start_high_reg <= clamp_fmt_pkg::clamp_start_high_rst;
      end_low_reg <= clamp_fmt_pkg::clamp_end_low_rst;
      end_high_reg <= clamp_fmt_pkg::clamp_end_high_rst;
      // RL11: siting and other format bits clear
      fmt_reg <= clamp_fmt_pkg::output_format_rst;
      rdata_reg <= 8'h00;
    end
    else
    begin
      // RL13: start time halves
      if (wr_start_low)
        start_low_reg <= req.wdata;
      if (wr_start_high)
        start_high_reg <= req.wdata[1:0];
      // RL3: end time halves
      if (wr_end_low)
        end_low_reg <= req.wdata;
      if (wr_end_high)
        end_high_reg <= req.wdata[1:0];
      // RL12: write bit 0 dropped
      if (wr_fmt)
        fmt_reg <= req.wdata[clamp_fmt_pkg::fmt_square_bit:
          clamp_fmt_pkg::fmt_siting_bit];
      rdata_reg <= req.rd ? rdata_next : 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;

  // ==========================================================
  // Field capture selection
  // RL7: per-field capture decision by field_capture_select
  always_comb
  begin
    case (fmt_reg.field_capture_select)
      3'h0: capture_next = 1'b0;
      3'h1: capture_next = (field_cnt_reg == 2'h0);
      3'h2: capture_next = !field_cnt_reg[0];
      3'h3: capture_next = field_odd && !field_cnt_reg[1];
      3'h4: capture_next = !field_odd && !field_cnt_reg[1];
      3'h5: capture_next = field_odd;
      3'h6: capture_next = !field_odd;
      default: capture_next = 1'b1;
    endcase
  end

  // Decision held for the whole field so a field is never cut
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      field_cnt_reg <= 2'h0;
      capture_reg <= 1'b0;
    end
    else if (field_start)
    begin
      field_cnt_reg <= field_cnt_reg + 2'h1;
      capture_reg <= capture_next;
    end
  end

  assign field_capture = capture_reg;

  // ==========================================================
  // Format outputs
  logic square_reg;
  logic burst_reg;
  logic aligned_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      square_reg <= 1'b0;
      burst_reg <= 1'b0;
      aligned_reg <= 1'b0;
    end
    else
    begin
      // RL6: pixel rate select
      square_reg <= fmt_reg.square_pixel;
      // RL8: transfer mode select
      burst_reg <= fmt_reg.burst_8bit;
      // RL10: chroma siting select
      aligned_reg <= fmt_reg.line_aligned_chroma;
    end
  end
  assign square_pixel = square_reg;
  assign burst_8bit = burst_reg;
  assign line_aligned_chroma = aligned_reg;

  // ==========================================================
  // Clamp pulse
  // RL5: pulse feeds converter clamp gate
  clamp_pulse_gen u_pulse
  (
    .clk(clk),
    .rst_b(rst_b),
    .hsync_detect(hsync_detect),
    .start_time({start_high_reg, start_low_reg}),
    .end_time({end_high_reg, end_low_reg}),
    .clamp_pulse(clamp_gate_input)
  );

  // RL9: pin drive gating
  output_drive_gate u_drive
  (
    .clk(clk),
    .rst_b(rst_b),
    .drive_enable(fmt_reg.output_drive_enable),
    .data_valid_in(data_valid_in && capture_reg),
    .pins_oe(output_drive_enable),
    .data_valid_out(data_valid_out)
  );

  // ==========================================================
  // Checks
  sequence fmt_write_s;
    wr_fmt;
  endsequence

  sequence fmt_read_s;
    req.rd && hit(req.addr, clamp_fmt_pkg::output_format_off);
  endsequence

  // RL12: bit 0 always reads zero
  fmt_bit0_a: assert property (@(posedge clk) disable iff (!rst_b) // RL12
    fmt_read_s |=> reg_rdata[0] == 1'b0)
    else $error("format bit 0 read non-zero");
  // RL6: square pixel follows written bit two cycles later
  square_sel_a: assert property (@(posedge clk) disable iff (!rst_b) // RL6
    fmt_write_s ##1 !wr_fmt |=> square_pixel == $past(reg_wdata[7], 2))
    else $error("square pixel select wrong");
  // RL8: burst mode follows write
  burst_sel_a: assert property (@(posedge clk) disable iff (!rst_b) // RL8
    fmt_write_s ##1 !wr_fmt |=> burst_8bit == $past(reg_wdata[3], 2))
    else $error("burst mode select wrong");
  // RL10: siting follows write
  siting_sel_a: assert property (@(posedge clk) disable iff (!rst_b) // RL10
    fmt_write_s ##1 !wr_fmt |=> line_aligned_chroma == $past(reg_wdata[1], 2))
    else $error("chroma siting select wrong");
  // RL9: data valid never high while pins float
  drive_gate_a: assert property (@(posedge clk) disable iff (!rst_b) // RL9
    data_valid_out |-> output_drive_enable)
    else $error("data valid while outputs floated");
  // RL7: no capture selected means no capture next field
  no_capture_a: assert property (@(posedge clk) disable iff (!rst_b) // RL7
    field_start && fmt_reg.field_capture_select == 3'h0 |=> !field_capture)
    else $error("capture with no fields selected");
  // RL3: end low byte reads back
  end_read_a: assert property (@(posedge clk) disable iff (!rst_b) // RL3
    req.rd && hit(req.addr, clamp_fmt_pkg::clamp_end_low_off)
    |=> reg_rdata == end_low_reg)
    else $error("end time low byte readback wrong");
  // RL4: upper end bits read with zeros above
  end_high_a: assert property (@(posedge clk) disable iff (!rst_b) // RL4
    req.rd && hit(req.addr, clamp_fmt_pkg::clamp_end_high_off)
    |=> reg_rdata[7:2] == 6'h00)
    else $error("unused end time bits non-zero");

  sequence end_low_wr_s;
    wr_end_low;
  endsequence

  sequence end_high_wr_s;
    wr_end_high;
  endsequence

  sequence all_sel_s;
    field_start && fmt_reg.field_capture_select == 3'h7;
  endsequence

  // RL3: low end byte takes the written value
  end_low_wr_a: assert property (@(posedge clk) disable iff (!rst_b) // RL3
    end_low_wr_s |=> end_low_reg == $past(reg_wdata))
    else $error("end time low byte not written");
  // RL3: upper end bits take written bits 1 and 0 only
  end_high_wr_a: assert property (@(posedge clk) disable iff (!rst_b) // RL3
    end_high_wr_s |=> end_high_reg == $past(reg_wdata[1:0]))
    else $error("end time upper bits not written");
  // RL13: start upper bits read with zeros above
  start_high_a: assert property (@(posedge clk) disable iff (!rst_b) // RL13
    req.rd && hit(req.addr, clamp_fmt_pkg::clamp_start_high_off)
    |=> reg_rdata == {6'h00, start_high_reg})
    else $error("start time upper bits readback wrong");
  // RL7: format readback carries the stored fields
  fmt_readback_a: assert property (@(posedge clk) disable iff (!rst_b) // RL7
    fmt_read_s |=> reg_rdata[7:1] == $past(fmt_reg))
    else $error("format register readback wrong");
  // RL9: pin drive follows written bit two cycles later
  drive_sel_a: assert property (@(posedge clk) disable iff (!rst_b) // RL9
    fmt_write_s ##1 !wr_fmt |=> output_drive_enable == $past(reg_wdata[2], 2))
    else $error("output drive enable wrong");
  // RL7: all fields selected captures every field
  all_capture_a: assert property (@(posedge clk) disable iff (!rst_b) // RL7
    all_sel_s |=> field_capture)
    else $error("field missed with all fields selected");
  // RL7: odd-only selection follows field parity
  odd_capture_a: assert property (@(posedge clk) disable iff (!rst_b) // RL7
    field_start && fmt_reg.field_capture_select == 3'h5
    |=> field_capture == $past(field_odd))
    else $error("odd field selection wrong");
  // RL7: even-only selection follows field parity
  even_capture_a: assert property (@(posedge clk) disable iff (!rst_b) // RL7
    field_start && fmt_reg.field_capture_select == 3'h6
    |=> field_capture == !$past(field_odd))
    else $error("even field selection wrong");
  // RL7: decision only changes at a field start, never mid-field
  field_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // RL7
    !field_start |=> field_capture == $past(field_capture))
    else $error("capture decision changed inside a field");
endmodule
`default_nettype wire

//--- hdl/clamp_fmt_pkg.sv
// Package: register map, field layout, reset values and carrier types
`default_nettype none
package clamp_fmt_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] clamp_start_low_off = 8'h12;
  localparam logic [7:0] clamp_start_high_off = 8'h13;
  localparam logic [7:0] clamp_end_low_off = 8'h14;
  localparam logic [7:0] clamp_end_high_off = 8'h15;
  localparam logic [7:0] output_format_off = 8'h16;
  // ==========================================================
  // Reset values
  localparam logic [7:0] clamp_start_low_rst = 8'h37;
  localparam logic [1:0] clamp_start_high_rst = 2'h0;
  localparam logic [7:0] clamp_end_low_rst = 8'h52;
  localparam logic [1:0] clamp_end_high_rst = 2'h0;
  localparam logic [6:0] output_format_rst = 7'h00;
  // ==========================================================
  // Output format field positions
  localparam int fmt_square_bit = 7;
  localparam int fmt_field_hi = 6;
  localparam int fmt_field_lo = 4;
  localparam int fmt_burst_bit = 3;
  localparam int fmt_drive_bit = 2;
  localparam int fmt_siting_bit = 1;
  // ==========================================================
  // Timing
  localparam int hsync_fixed_delay = 1;
  localparam int line_count_width = 10;

  typedef struct packed {
    logic square_pixel;
    logic [2:0] field_capture_select;
    logic burst_8bit;
    logic output_drive_enable;
    logic line_aligned_chroma;
  } output_format_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage
`default_nettype wire

//--- hdl/clamp_pulse_gen.sv
// Clamp pulse generator: per-line counter from horizontal sync fall
`default_nettype none
module clamp_pulse_gen
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Sync and window
  input wire logic hsync_detect,
  input wire logic [9:0] start_time,
  input wire logic [9:0] end_time,
  // Pulse
  output logic clamp_pulse
);
  // ==========================================================
  // Line counter
  logic hsync_d_reg;
  logic [9:0] count_reg;
  logic [9:0] count_next;
  logic pulse_reg;
  logic pulse_next;
  wire hsync_fall = hsync_d_reg && !hsync_detect;
  wire count_at_max = (count_reg == 10'h3ff);

  // RL2: fixed delay, count restarts at zero one clock after the fall
  assign count_next = hsync_fall ? 10'h000 :
    (count_at_max ? count_reg : count_reg + 10'h001);
  // RL1 RL14: window from start, ending at end
  assign pulse_next = (count_next >= start_time) && (count_next < end_time);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      hsync_d_reg <= 1'b0;
      count_reg <= 10'h3ff;
      pulse_reg <= 1'b0;
    end
    else
    begin
      hsync_d_reg <= hsync_detect;
      count_reg <= count_next;
      pulse_reg <= pulse_next;
    end
  end

  assign clamp_pulse = pulse_reg;

  // ==========================================================
  // Checks
  sequence fall_s;
    hsync_d_reg && !hsync_detect;
  endsequence

  // RL1: pulse ends exactly at end count
  end_timing_a: assert property (@(posedge clk) disable iff (!rst_b) // RL1
    (count_reg == end_time) && !$past(hsync_fall) |-> !clamp_pulse)
    else $error("clamp pulse still high at end count");
  // RL2: counter zero one cycle after the fall
  restart_delay_a: assert property (@(posedge clk) disable iff (!rst_b) // RL2
    fall_s |=> count_reg == 10'h000)
    else $error("line counter did not restart after sync fall");
endmodule
`default_nettype wire

//--- hdl/output_drive_gate.sv
// Output pin gating: drive enables and data valid from output format
`default_nettype none
module output_drive_gate
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic drive_enable,
  input wire logic data_valid_in,
  // Pins
  output logic pins_oe,
  output logic data_valid_out
);
  logic oe_reg;
  logic valid_reg;

  // RL9: pins driven only while enabled
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      oe_reg <= 1'b0;
      valid_reg <= 1'b0;
    end
    else
    begin
      oe_reg <= drive_enable;
      valid_reg <= drive_enable && data_valid_in;
    end
  end

  assign pins_oe = oe_reg;
  assign data_valid_out = valid_reg;
endmodule
`default_nettype wire

//--- tb/capture_sink.sv
// Capture processor model counting fields seen on the data port
`default_nettype none
module capture_sink
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Data port
  input wire logic drive_en,
  input wire logic valid,
  output logic [15:0] field_cnt,
  output logic float_err
);
  timeunit 1ns;
  timeprecision 1ns;
  logic valid_reg;
  // ==========================================================
  // Field counting
  // one burst of valid per captured field, floated pins
  always_ff @(posedge clk)
  begin
    valid_reg <= rst_b & valid;
    if (!rst_b)
    begin
      field_cnt <= 16'h0000;
      float_err <= 1'b0;
    end
    else
    begin
      if (valid && !valid_reg)
        field_cnt <= field_cnt + 16'h0001;
      if (valid && !drive_en)
        float_err <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- tb/dc_restore_end_and_output_format_bench.sv
// Self-checking bench for clamp window and output format registers
`default_nettype none
module dc_restore_end_and_output_format_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic hsync_detect = 1'b0;
  logic field_odd = 1'b0;
  logic field_start = 1'b0;
  logic data_valid_in = 1'b0;
  logic [7:0] reg_rdata;
  logic clamp_gate_input, square_pixel, burst_8bit, line_aligned_chroma;
  logic field_capture, output_drive_enable, data_valid_out, float_err;
  logic [15:0] field_cnt;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;

  clamp_fmt_regs clamp_fmt_regs_inst (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hsync_detect(hsync_detect),
    .field_odd(field_odd), .field_start(field_start),
    .data_valid_in(data_valid_in), .clamp_gate_input(clamp_gate_input),
    .square_pixel(square_pixel), .burst_8bit(burst_8bit),
    .line_aligned_chroma(line_aligned_chroma),
    .field_capture(field_capture),
    .output_drive_enable(output_drive_enable),
    .data_valid_out(data_valid_out));

  capture_sink capture_sink_inst (.clk(clk), .rst_b(rst_b),
    .drive_en(output_drive_enable), .valid(data_valid_out),
    .field_cnt(field_cnt), .float_err(float_err));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Checking and closing
  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    num_checks++;
    if (got !== want)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  // Hang guard, well above the roughly 10k cycles of the run
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      error_cnt++;
      results();
    end
  end

  // ==========================================================
  // Register port
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, want});
  endtask

  // ==========================================================
  // Clamp window over one line
  task automatic line(input logic [9:0] s, input logic [9:0] e);
    int first = 0;
    int hits = 0;
    wr(8'h12, s[7:0]);
    wr(8'h13, {6'($urandom), s[9:8]});
    wr(8'h14, e[7:0]);
    wr(8'h15, {6'($urandom), e[9:8]});
    rd(8'h13, {6'h00, s[9:8]});
    rd(8'h15, {6'h00, e[9:8]});
    rd(8'h14, e[7:0]);
    @(posedge clk);
    hsync_detect <= 1'b1;
    @(posedge clk);
    hsync_detect <= 1'b0;
    // Sample i is i clocks after the sync fall, so count zero is seen too
    for (int i = 1; i < 1100; i++)
    begin
      @(posedge clk);
      #1;
      if (clamp_gate_input === 1'b1)
      begin
        hits++;
        if (first == 0)
          first = i;
      end
    end
    chk(16'(hits), (e > s) ? 16'(e - s) : 16'h0000);
    chk(16'(first), (e > s) ? 16'(s) + 16'h0001 : 16'h0000);
  endtask

  // ==========================================================
  // Field capture cadence over eight alternating fields
  function automatic logic [15:0] fld_exp(input logic [2:0] c);
    case (c)
      3'h0: return 16'h0000;
      3'h1, 3'h3, 3'h4: return 16'h0002;
      3'h7: return 16'h0008;
      default: return 16'h0004;
    endcase
  endfunction

  task automatic fields(input logic [2:0] c, input logic drv);
    logic [15:0] base;
    int caps = 0;
    wr(8'h16, {1'b0, c, 1'b0, drv, 2'b00});
    repeat (3) @(posedge clk);
    #1;
    base = field_cnt;
    @(posedge clk);
    for (int f = 0; f < 8; f++)
    begin
      field_start <= 1'b1;
      field_odd <= f[0];
      @(posedge clk);
      field_start <= 1'b0;
      repeat (2) @(posedge clk);
      // Decision settled since the field start edge
      if (field_capture === 1'b1)
        caps++;
      data_valid_in <= 1'b1;
      repeat (3) @(posedge clk);
      data_valid_in <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (3) @(posedge clk);
    #1;
    chk(field_cnt - base, drv ? fld_exp(c) : 16'h0000);
    chk(16'(caps), fld_exp(c));
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [7:0] v;
    logic [15:0] got;
    void'($urandom(32'h798fceb5));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk({15'h0000, line_aligned_chroma}, 16'h0000);
    rd(8'h12, 8'h37);
    rd(8'h13, 8'h00);
    rd(8'h14, 8'h52);
    rd(8'h15, 8'h00);
    rd(8'h16, 8'h00);
    wr(8'h17, 8'hff);
    rd(8'h17, 8'h00);
    rd(8'h14, 8'h52);
    for (int i = 0; i < 12; i++)
    begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h01 : 8'($urandom);
      wr(8'h16, v);
      repeat (2) @(posedge clk);
      #1;
      got = {12'h000, square_pixel, burst_8bit, line_aligned_chroma,
        output_drive_enable};
      chk(got, {12'h000, v[7], v[3], v[1], v[2]});
      rd(8'h16, v & 8'hfe);
    end
    // Corner windows first: reset values, upper bits, empty, reversed
    line(10'h037, 10'h052);
    line(10'h100, 10'h103);
    line(10'h005, 10'h005);
    line(10'h009, 10'h003);
    repeat (4) line(10'($urandom % 64), 10'($urandom % 64));
    for (int c = 0; c < 8; c++)
      fields(3'(c), 1'b1);
    fields(3'h7, 1'b0);
    chk({15'h0000, float_err}, 16'h0000);
    results();
  end
endmodule
`default_nettype wire
